// File: logic/sacr_pkg.sv
// Constants and types for the service acknowledge and service channel registers.
// Assumes an 8-bit host register bus that runs on the device clock.
package sacr_pkg;

  // Word-bus map offsets
  localparam logic [7:0] SACR_W_RX_ACK = 8'hEE; // Receive service acknowledge
  localparam logic [7:0] SACR_W_SC_A = 8'h82; // Service channel a
  localparam logic [7:0] SACR_W_SC_B = 8'h84; // Service channel b
  localparam logic [7:0] SACR_W_SC_C = 8'h86; // Service channel c
  localparam logic [7:0] SACR_W_CHSEL = 8'hC8; // Channel select
  // 8-bit map offsets
  localparam logic [7:0] SACR_B_RX_ACK = 8'h77;
  localparam logic [7:0] SACR_B_SC_A = 8'h41;
  localparam logic [7:0] SACR_B_SC_B = 8'h42;
  localparam logic [7:0] SACR_B_SC_C = 8'h43;
  localparam logic [7:0] SACR_B_CHSEL = 8'h64;

  // Values after reset
  localparam logic [7:0] SACR_RX_ACK_RST = 8'h80; // Ack register default / idle answer
  localparam logic [7:0] SACR_SC_RST = 8'h00; // Service channel registers
  localparam logic [2:0] SACR_CHSEL_RST = 3'h0; // Channel select
  localparam logic [7:0] SACR_UNMAPPED = 8'h00; // Answer to unmapped reads

  // Channel field position inside a service channel byte
  localparam int SACR_CH_LSB = 2;
  localparam int SACR_CH_MSB = 4;

  // Register selected by an address
  typedef enum logic [2:0] {
    SACR_SEL_NONE = 3'h0,
    SACR_SEL_ACK = 3'h1,
    SACR_SEL_SC_A = 3'h2,
    SACR_SEL_SC_B = 3'h3,
    SACR_SEL_SC_C = 3'h4,
    SACR_SEL_CHSEL = 3'h5
  } sacr_sel_t;

  // Service state, one-hot
  typedef enum logic [1:0] {
    SACR_ST_IDLE = 2'b01,
    SACR_ST_CTX = 2'b10
  } sacr_state_t;

endpackage

// File: logic/sacr_chan_merge.sv
// Masks a three-bit channel number into bits 4:2 of a stored service channel byte.
// Purely combinational; the caller registers the result before it reaches a pin.
`timescale 1ns/1ps
module sacr_chan_merge
  import sacr_pkg::*;
(
  input wire logic [7:0] stored_in,
  input wire logic [2:0] chan_in,
  output logic [7:0] merged_out
);

  // User bits pass, channel bits are replaced; the store itself is untouched
  always_comb begin
    merged_out = stored_in;
    merged_out[SACR_CH_MSB:SACR_CH_LSB] = chan_in;
  end

endmodule // sacr_chan_merge

// File: logic/sacr_top.sv
// Service acknowledge and service channel registers of an eight-channel controller.
// Assumes host strobes are synchronous one-cycle pulses on CLK_SYS_IN; map select
// and ack enable come from pins and are synchronised here.
//
// What this block does
// - Acknowledge registers read-only, read returns vector
// - Ack read is acknowledge cycle, may pass down
// - Receive ack: 8 bits, default 80, mapped
// - Three channel registers, reset zero, mapped
// - Reads substitute channel number into bits 4:2
// - Substitution never changes stored contents
// - In service context: requesting channel number
// - Outside context: channel select register value
// - Channel field binary, channels 0 to 7
// - Bits 7:5 and 1:0 kept as user storage
// - Channel select bits 2:0 hold access channel
`timescale 1ns/1ps
module sacr_top
  import sacr_pkg::*;
(
  input wire logic CLK_SYS_IN,
  input wire logic RESET_N_IN,
  input wire logic [7:0] HOST_ADDR_IN,
  input wire logic [7:0] HOST_WDATA_IN,
  input wire logic HOST_RD_IN,
  input wire logic HOST_WR_IN,
  input wire logic MAP_8BIT_IN,
  input wire logic REG_ACK_EN_IN,
  input wire logic SVC_REQ_IN,
  input wire logic [2:0] SVC_REQ_CHAN_IN,
  input wire logic [7:0] SVC_VECTOR_IN,
  input wire logic SVC_END_IN,
  output logic [7:0] HOST_RDATA_OUT,
  output logic HOST_RVALID_OUT,
  output logic ACK_TAKEN_OUT,
  output logic ACK_PASS_OUT,
  output logic SVC_CONTEXT_OUT,
  output logic [2:0] CONTEXT_CHAN_OUT
);

  // All block state in one record
  typedef struct packed {
    sacr_state_t state; // Idle or inside a service routine
    logic [2:0] ctx_chan; // Channel that was acknowledged
    logic [7:0] sc_a; // Stored service channel bytes
    logic [7:0] sc_b;
    logic [7:0] sc_c;
    logic [2:0] chan_sel; // Channel for accesses outside service
    logic [7:0] rdata; // Read data register
    logic rvalid; // Read answer pulse
    logic ack_taken; // Local acknowledge pulse
    logic ack_pass; // Acknowledge handed down the chain
    logic map_meta; // Map select synchroniser
    logic map_sync;
    logic en_meta; // Ack enable synchroniser
    logic en_sync;
  } sacr_regs_t;

  sacr_regs_t s_r; // Current state
  sacr_regs_t s_nxt; // Next state
  sacr_sel_t sel; // Register addressed this cycle
  logic [7:0] sc_stored; // Stored byte of addressed channel register
  logic [2:0] chan_src; // Channel number to mask in
  logic [7:0] sc_merged; // Byte as the host sees it
  logic rd_go; // Read accepted (write has priority)

  // Address decode for either map, shared by read and write paths
  function automatic sacr_sel_t decode(input logic [7:0] addr, input logic map8);
    sacr_sel_t r;
    r = SACR_SEL_NONE;
    if (map8) begin
      if (addr == SACR_B_RX_ACK) r = SACR_SEL_ACK;
      else if (addr == SACR_B_SC_A) r = SACR_SEL_SC_A;
      else if (addr == SACR_B_SC_B) r = SACR_SEL_SC_B;
      else if (addr == SACR_B_SC_C) r = SACR_SEL_SC_C;
      else if (addr == SACR_B_CHSEL) r = SACR_SEL_CHSEL;
    end else begin
      if (addr == SACR_W_RX_ACK) r = SACR_SEL_ACK;
      else if (addr == SACR_W_SC_A) r = SACR_SEL_SC_A;
      else if (addr == SACR_W_SC_B) r = SACR_SEL_SC_B;
      else if (addr == SACR_W_SC_C) r = SACR_SEL_SC_C;
      else if (addr == SACR_W_CHSEL) r = SACR_SEL_CHSEL;
    end
    return r;
  endfunction

  assign sel = decode(HOST_ADDR_IN, s_r.map_sync);
  assign rd_go = HOST_RD_IN && !HOST_WR_IN;

  // Pick the stored byte and the channel source
  always_comb begin
    unique case (sel)
      SACR_SEL_SC_A: sc_stored = s_r.sc_a;
      SACR_SEL_SC_B: sc_stored = s_r.sc_b;
      SACR_SEL_SC_C: sc_stored = s_r.sc_c;
      default: sc_stored = SACR_SC_RST; // Not a channel register
    endcase
    // Context picks the acknowledged channel, else the select register
    if (s_r.state == SACR_ST_CTX) begin
      chan_src = s_r.ctx_chan;
    end else begin
      chan_src = s_r.chan_sel;
    end
  end

  // Mask the channel into a copy only; storage keeps its own bits
  sacr_chan_merge sacr_chan_merge_inst (
    .stored_in(sc_stored),
    .chan_in(chan_src),
    .merged_out(sc_merged)
  );

  // Next-state logic
  always_comb begin
    s_nxt = s_r;
    s_nxt.rvalid = 1'b0;
    s_nxt.ack_taken = 1'b0;
    s_nxt.ack_pass = 1'b0;
    // Pin levels pass two flops before use
    s_nxt.map_meta = MAP_8BIT_IN;
    s_nxt.map_sync = s_r.map_meta;
    s_nxt.en_meta = REG_ACK_EN_IN;
    s_nxt.en_sync = s_r.en_meta;
    // End of service first, so an ack in the same cycle wins
    if (SVC_END_IN) begin
      s_nxt.state = SACR_ST_IDLE;
    end
    if (HOST_WR_IN) begin
      // Channel registers store whole bytes, channel select only bits 2:0; channel bits are overridden only on read
      unique case (sel)
        SACR_SEL_SC_A: s_nxt.sc_a = HOST_WDATA_IN;
        SACR_SEL_SC_B: s_nxt.sc_b = HOST_WDATA_IN;
        SACR_SEL_SC_C: s_nxt.sc_c = HOST_WDATA_IN;
        SACR_SEL_CHSEL: s_nxt.chan_sel = HOST_WDATA_IN[2:0];
        SACR_SEL_ACK: ; // Read-only, no cycle started
        SACR_SEL_NONE: ; // Unmapped write dropped
      endcase
    end else if (rd_go) begin
      unique case (sel)
        SACR_SEL_ACK: begin
          if (!s_r.en_sync) begin
            // Without ack enable the cycle is not run; idle value returned
            s_nxt.rdata = SACR_RX_ACK_RST;
            s_nxt.rvalid = 1'b1;
          end else if (SVC_REQ_IN) begin
            // Local request answers the acknowledge
            s_nxt.rdata = SVC_VECTOR_IN;
            s_nxt.rvalid = 1'b1;
            s_nxt.ack_taken = 1'b1;
            s_nxt.state = SACR_ST_CTX;
            s_nxt.ctx_chan = SVC_REQ_CHAN_IN;
          end else begin
            // Nothing local: a device further down answers
            s_nxt.ack_pass = 1'b1;
          end
        end
        SACR_SEL_SC_A, SACR_SEL_SC_B, SACR_SEL_SC_C: begin
          s_nxt.rdata = sc_merged;
          s_nxt.rvalid = 1'b1;
        end
        SACR_SEL_CHSEL: begin
          s_nxt.rdata = {5'h00, s_r.chan_sel};
          s_nxt.rvalid = 1'b1;
        end
        SACR_SEL_NONE: begin
          s_nxt.rdata = SACR_UNMAPPED; // Defined answer to unmapped address
          s_nxt.rvalid = 1'b1;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      s_r.state <= SACR_ST_IDLE;
      s_r.ctx_chan <= SACR_CHSEL_RST;
      s_r.sc_a <= SACR_SC_RST;
      s_r.sc_b <= SACR_SC_RST;
      s_r.sc_c <= SACR_SC_RST;
      s_r.chan_sel <= SACR_CHSEL_RST;
      s_r.rdata <= SACR_RX_ACK_RST;
      s_r.rvalid <= 1'b0;
      s_r.ack_taken <= 1'b0;
      s_r.ack_pass <= 1'b0;
      s_r.map_meta <= 1'b0;
      s_r.map_sync <= 1'b0;
      s_r.en_meta <= 1'b0;
      s_r.en_sync <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from flops; SVC_CONTEXT_OUT decodes the state register
  assign HOST_RDATA_OUT = s_r.rdata;
  assign HOST_RVALID_OUT = s_r.rvalid;
  assign ACK_TAKEN_OUT = s_r.ack_taken;
  assign ACK_PASS_OUT = s_r.ack_pass;
  assign SVC_CONTEXT_OUT = (s_r.state == SACR_ST_CTX);
  assign CONTEXT_CHAN_OUT = s_r.ctx_chan;

  // Checks
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RESET_N_IN);

  sequence ack_read_s;
    rd_go && sel == SACR_SEL_ACK && s_r.en_sync;
  endsequence

  // Write, one cycle with no other write to the same register, then the read back
  sequence sc_a_write_then_read_s;
    HOST_WR_IN && sel == SACR_SEL_SC_A ##1 !(HOST_WR_IN && sel == SACR_SEL_SC_A)
      ##1 rd_go && sel == SACR_SEL_SC_A;
  endsequence

  chk_ack_no_write: assert property (
    HOST_WR_IN && sel == SACR_SEL_ACK |=> $stable(s_r.state) && !ACK_TAKEN_OUT
      && !ACK_PASS_OUT && !HOST_RVALID_OUT)
    else $error("write to ack register had an effect");

  chk_ack_vector: assert property (
    ack_read_s and SVC_REQ_IN |=> HOST_RVALID_OUT && ACK_TAKEN_OUT
      && HOST_RDATA_OUT == $past(SVC_VECTOR_IN) && SVC_CONTEXT_OUT)
    else $error("ack read did not return vector");

  chk_ack_pass: assert property (
    ack_read_s and !SVC_REQ_IN |=> ACK_PASS_OUT && !HOST_RVALID_OUT
      ##1 (!ACK_PASS_OUT || $past(rd_go && sel == SACR_SEL_ACK)))
    else $error("ack not handed down the chain");

  chk_ack_idle_val: assert property (
    rd_go && sel == SACR_SEL_ACK && !s_r.en_sync |=> HOST_RDATA_OUT == 8'h80
      && !ACK_TAKEN_OUT)
    else $error("ack read without enable misbehaved");

  chk_chan_ctx: assert property (
    rd_go && (sel == SACR_SEL_SC_A || sel == SACR_SEL_SC_B || sel == SACR_SEL_SC_C)
      && SVC_CONTEXT_OUT
      |=> HOST_RDATA_OUT[4:2] == $past(s_r.ctx_chan))
    else $error("context channel not masked in");

  chk_chan_idle: assert property (
    rd_go && (sel == SACR_SEL_SC_A || sel == SACR_SEL_SC_B || sel == SACR_SEL_SC_C)
      && !SVC_CONTEXT_OUT
      |=> HOST_RDATA_OUT[4:2] == $past(s_r.chan_sel))
    else $error("channel select not masked in");

  chk_user_bits: assert property (
    sc_a_write_then_read_s |=> HOST_RDATA_OUT[7:5] == $past(HOST_WDATA_IN[7:5], 3)
      && HOST_RDATA_OUT[1:0] == $past(HOST_WDATA_IN[1:0], 3))
    else $error("user bits lost");

  chk_store_kept: assert property (
    rd_go && sel == SACR_SEL_SC_A |=> s_r.sc_a == $past(s_r.sc_a))
    else $error("read changed stored byte");

  chk_ctx_hold: assert property (
    SVC_CONTEXT_OUT && !SVC_END_IN |=> SVC_CONTEXT_OUT)
    else $error("service context dropped early");

endmodule // sacr_top

// File: tb/sacr_host_model.sv
// Host processor model that drives the register bus of the service channel block.
// Assumes one-cycle strobes taken on the rising edge and an answer one cycle later.
`timescale 1ns/1ps
module sacr_host_model (
  input wire logic clk_in,
  input wire logic [7:0] rdata_in,
  input wire logic rvalid_in,
  input wire logic taken_in,
  input wire logic pass_in,
  output logic [7:0] addr_out,
  output logic [7:0] wdata_out,
  output logic rd_out,
  output logic wr_out
);
  logic [7:0] got_data; // Data seen in the answer cycle
  logic [2:0] got_flags; // Read valid, local ack, passed ack

  // Bus idles with no strobe from time zero
  initial begin
    addr_out = 8'h00;
    wdata_out = 8'h00;
    rd_out = 1'b0;
    wr_out = 1'b0;
  end

  // One bus cycle; idle address and data are inverted so a stale value never matches
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    #1;
    addr_out = a;
    wdata_out = d;
    rd_out = !wr;
    wr_out = wr;
    @(posedge clk_in);
    #1;
    rd_out = 1'b0;
    wr_out = 1'b0;
    addr_out = ~a;
    wdata_out = ~d;
    got_data = rdata_in;
    got_flags = {rvalid_in, taken_in, pass_in};
  endtask
endmodule // sacr_host_model

// File: tb/sacr_top_bench.sv
// Self-checking bench for the service acknowledge and service channel registers.
// Assumes the host model drives the bus; service request pins are driven here.
`timescale 1ns/1ps
module sacr_top_bench;
  import sacr_pkg::*;
  logic clk, rst_n, rd, wr, map8, acken, req, send, rvalid, taken, pass, ctx;
  logic [7:0] addr, wdata, vec, rdata;
  logic [2:0] reqch, ctxch;
  int bad_count = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [7:0] ra, rdat, rexp;
  logic [2:0] rch;
  // Rows: address, written byte, channel select, expected read byte
  logic [26:0] rows [8] = '{{8'h82, 8'hFF, 3'h0, 8'hE3}, {8'h84, 8'h00, 3'h7, 8'h1C},
    {8'h86, 8'hA5, 3'h5, 8'hB5}, {8'h82, 8'h5A, 3'h2, 8'h4A}, {8'h84, 8'h3C, 3'h1, 8'h24},
    {8'h86, 8'hC3, 3'h3, 8'hCF}, {8'h82, 8'h0F, 3'h4, 8'h13}, {8'h86, 8'hF0, 3'h6, 8'hF8}};

  sacr_top sacr_top_inst (.CLK_SYS_IN(clk), .RESET_N_IN(rst_n), .HOST_ADDR_IN(addr),
    .HOST_WDATA_IN(wdata), .HOST_RD_IN(rd), .HOST_WR_IN(wr), .MAP_8BIT_IN(map8),
    .REG_ACK_EN_IN(acken), .SVC_REQ_IN(req), .SVC_REQ_CHAN_IN(reqch), .SVC_VECTOR_IN(vec),
    .SVC_END_IN(send), .HOST_RDATA_OUT(rdata), .HOST_RVALID_OUT(rvalid),
    .ACK_TAKEN_OUT(taken), .ACK_PASS_OUT(pass), .SVC_CONTEXT_OUT(ctx),
    .CONTEXT_CHAN_OUT(ctxch));

  sacr_host_model sacr_host_model_inst (.clk_in(clk), .rdata_in(rdata), .rvalid_in(rvalid),
    .taken_in(taken), .pass_in(pass), .addr_out(addr), .wdata_out(wdata), .rd_out(rd),
    .wr_out(wr));

  // 50 MHz system clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Hang guard; the whole run needs about a hundred cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      bad_count++;
      stop_test();
    end
  end

  // Counts and reports one comparison
  task automatic check(input string nm, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Read, then compare data (only when an answer is expected) and the pulse flags
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] ed,
    input logic [2:0] ef);
    sacr_host_model_inst.xfer(1'b0, a, 8'h00);
    if (ef[2]) begin
      check(nm, ed, sacr_host_model_inst.got_data);
    end
    check(nm, {5'h00, ef}, {5'h00, sacr_host_model_inst.got_flags});
  endtask

  // Verdict and end of run
  task automatic stop_test();
    if (bad_count == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    rst_n = 1'b0;
    map8 = 1'b0;
    acken = 1'b0;
    req = 1'b0;
    reqch = 3'h0;
    vec = 8'h00;
    send = 1'b0;
    repeat (6) @(posedge clk);
    #1 rst_n = 1'b1;
    rd_chk("ack_rst", SACR_W_RX_ACK, 8'h80, 3'h4);
    rd_chk("sc_rst", SACR_W_SC_C, 8'h00, 3'h4);
    rd_chk("unmapped", 8'h10, 8'h00, 3'h4);
    // Ordinary cases: every channel number, all three registers, user bits both ways
    for (int i = 0; i < 8; i++) begin
      {ra, rdat, rch, rexp} = rows[i];
      sacr_host_model_inst.xfer(1'b1, SACR_W_CHSEL, {5'h00, rch});
      sacr_host_model_inst.xfer(1'b1, ra, rdat);
      rd_chk("sc_read", ra, rexp, 3'h4);
    end
    rd_chk("chsel", SACR_W_CHSEL, 8'h06, 3'h4);
    rd_chk("sc_kept", SACR_W_SC_B, 8'h38, 3'h4);
    // Enable acknowledge before relying on it; the pin sync needs a few edges
    req = 1'b1;
    reqch = 3'h3;
    vec = 8'h5C;
    acken = 1'b1;
    repeat (4) @(posedge clk);
    sacr_host_model_inst.xfer(1'b1, SACR_W_RX_ACK, 8'hFF);
    check("wr_ack_ctx", 8'h00, {7'h00, ctx});
    rd_chk("ack_local", SACR_W_RX_ACK, 8'h5C, 3'h6);
    check("ctx_chan", 8'h0B, {4'h0, ctx, ctxch});
    rd_chk("sc_ctx", SACR_W_SC_C, 8'hEC, 3'h4);
    @(posedge clk);
    #1 send = 1'b1;
    @(posedge clk);
    #1 send = 1'b0;
    check("ctx_end", 8'h00, {7'h00, ctx});
    rd_chk("sc_noctx", SACR_W_SC_C, 8'hF8, 3'h4);
    req = 1'b0;
    rd_chk("ack_pass", SACR_W_RX_ACK, 8'h00, 3'h1);
    map8 = 1'b1;
    repeat (4) @(posedge clk);
    rd_chk("map8_sc", SACR_B_SC_C, 8'hF8, 3'h4);
    rd_chk("map8_ack", SACR_B_RX_ACK, 8'h00, 3'h1);
    // Mid-run reset: word map again, every register back to its default
    map8 = 1'b0;
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check("rst_rdata", SACR_RX_ACK_RST, rdata);
    check("rst_ctx", 8'h00, {4'h0, ctx, ctxch});
    rst_n = 1'b1;
    rd_chk("rst_sc", SACR_W_SC_C, 8'h00, 3'h4);
    rd_chk("rst_chsel", SACR_W_CHSEL, 8'h00, 3'h4);
    stop_test();
  end
endmodule // sacr_top_bench
